// *** hdl/sirf_pkg.sv ***
// Purpose: constants shared by the supply integrity and reset flag logic
// Assumes: 40 MHz ref_clk, 8-bit register port
// Notes: times kept in their own unit, cycle counts derived from the clock rate
package sirf_pkg;
	// clock rate
	localparam int unsigned CLK_FREQ_KHZ   = 40000;
	// register port widths
	localparam int unsigned ADDR_W         = 8;
	localparam int unsigned DATA_W         = 8;
	// register offsets
	localparam logic [7:0] OFS_INTEGRITY   = 8'h3a; // integrity_ctrl_status
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h3b; // sticky event bits, read only
	localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h3c; // event enable mask
	localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h3d; // write one to clear, write only
	// field positions in integrity_ctrl_status
	localparam int unsigned BIT_BROWNOUT   = 2;
	localparam int unsigned BIT_TRIM_LO    = 5;
	localparam int unsigned BIT_TRIM_HI    = 6;
	// event bit positions in the interrupt registers
	localparam int unsigned EV_W           = 3;
	localparam int unsigned EV_LVD         = 0;
	localparam int unsigned EV_WDG         = 1;
	localparam int unsigned EV_ILLEGAL     = 2;
	// values after reset
	localparam logic [1:0] RST_TRIM_LO     = 2'h0;
	localparam logic       RST_BROWNOUT    = 1'b0;
	localparam logic [2:0] RST_IRQ_EN      = 3'h0;
	// wake filter time, 33 us typical, rounded down to whole cycles
	localparam int unsigned WAKE_FILTER_NS = 33000;
	localparam int unsigned WAKE_FILTER_CYC = (WAKE_FILTER_NS * CLK_FREQ_KHZ) / 1000000;
	localparam int unsigned DIP_CNT_W      = 11;
	// length of a pulse reset from watchdog or illegal code
	localparam int unsigned PULSE_RST_CYC  = 64;
	localparam int unsigned PULSE_CNT_W    = 7;
endpackage

// *** hdl/sirf_sync3.sv ***
// Purpose: three-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels from pins or analog comparators
// Notes: output moves only once the second and third stages agree
`timescale 1ns/1ps
module sirf_sync3 #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	// whole state of the synchroniser
	typedef struct packed {
		logic [WIDTH-1:0] s1; // first stage, read only by s2
		logic [WIDTH-1:0] s2; // second stage
		logic [WIDTH-1:0] s3; // third stage
		logic [WIDTH-1:0] q;  // agreed value
	} sirf_sync_t;

	sirf_sync_t cur;
	sirf_sync_t next_cur;

	// shift chain and agreement check per bit
	always_comb begin
		next_cur    = cur;
		next_cur.s1 = async_in;
		next_cur.s2 = cur.s1;
		next_cur.s3 = cur.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (cur.s2[i] == cur.s3[i]) begin
				next_cur.q[i] = cur.s3[i];
			end
		end
	end

	// register the state
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cur <= {INIT, INIT, INIT, INIT};
		end else begin
			cur <= next_cur;
		end
	end

	assign sync_out = cur.q;
endmodule

// *** hdl/sirf_top.sv ***
// Purpose: supply integrity reset, reset pin drive and reset cause flags
// Assumes: rstn is the power-on reset of this block only; chip_reset feeds the rest of the chip
// Notes: comparator and pin inputs are asynchronous and pass sirf_sync3
//
// Function
// (R1) hold chip reset below threshold, with hysteresis
// (R2) drive reset pin low during supply reset
// (R3) supply reset clears watchdog reset flag
// (R4) supply reset sets brownout flag, read clears
// (R5) other resets never clear brownout flag
// (R6) disabled detector leaves brownout flag meaningless
// (R7) dip shorter than wake filter sets no flag
// (R8) external clock: no flag in halt, needs fast
// (R9) trim low bits in bits six and five
// (R10) software writes zero to reserved bits
// (R11) register at 3a, resets to zero
// (R12) illegal opcode or prebyte causes chip reset
// (R13) options enable detector and pick high threshold
// (R14) disabled detector ignores comparator, no reset
// (R15) only reads clear flag, writes touch trim
`timescale 1ns/1ps
module sirf_top
	import sirf_pkg::*;
#(
	parameter int unsigned FILTER_CYC = sirf_pkg::WAKE_FILTER_CYC,
	parameter int unsigned PULSE_CYC  = sirf_pkg::PULSE_RST_CYC
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rstn,
	input  wire logic [sirf_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [sirf_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [sirf_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                        opt_detector_en,
	input  wire logic                        opt_high_threshold,
	input  wire logic                        cmp_above_rising,
	input  wire logic                        cmp_above_falling,
	input  wire logic                        clk_src_external,
	input  wire logic                        ext_clk_fast,
	input  wire logic                        in_halt,
	input  wire logic                        wdg_reset_req,
	input  wire logic                        wdg_flag_clr,
	input  wire logic                        illegal_opcode,
	input  wire logic                        illegal_prebyte,
	input  wire logic                        reset_pin_in,
	output logic                             reset_pin_out,
	output logic                             reset_pin_oe_n,
	output logic                             chip_reset,
	output logic                             threshold_high_sel,
	output logic                             watchdog_reset_flag,
	output logic      [1:0]                  rc_trim_low,
	output logic                             irq
);
	// reset sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_RUN    = 3'b001, // supply good, no reset
		ST_SUPPLY = 3'b010, // static supply reset
		ST_PULSE  = 3'b100  // timed reset from watchdog or illegal code
	} sirf_state_e;

	// whole state of the block
	typedef struct packed {
		sirf_state_e             state;     // reset sequencer
		logic [DIP_CNT_W-1:0]    dip_cnt;   // length of current supply dip
		logic                    dip_halt;  // dip began while halted
		logic [PULSE_CNT_W-1:0]  pulse_cnt; // cycles left of a pulse reset
		logic                    brownout;  // brownout_reset_flag
		logic                    wdg_flag;  // watchdog_reset_flag
		logic [1:0]              trim_lo;   // rc_trim_low
		logic [EV_W-1:0]         ev_stat;   // sticky events
		logic [EV_W-1:0]         ev_en;     // event enables
		logic [DATA_W-1:0]       rdata;     // read data, one cycle after strobe
		logic                    chip_rst;  // chip reset level
		logic                    pin_oe_n;  // reset pin drive, low drives
		logic                    thr_sel;   // threshold select to comparator
		logic                    irq;       // interrupt level
	} sirf_state_t;

	sirf_state_t cur;
	sirf_state_t next_cur;

	// synchronised asynchronous inputs
	logic [2:0] sync_q;
	logic       above_rise;
	logic       above_fall;
	logic       pin_high;

	// pin idles high, comparators assume low supply until told otherwise
	sirf_sync3 #(
		.WIDTH (3),
		.INIT  (3'h4)
	) u_sync (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.async_in ({reset_pin_in, cmp_above_falling, cmp_above_rising}),
		.sync_out (sync_q)
	);

	assign above_rise = sync_q[0];
	assign above_fall = sync_q[1];
	assign pin_high   = sync_q[2];

	// pack the integrity register as software sees it
	function automatic logic [DATA_W-1:0] integrity_word(input logic [1:0] trim, input logic flag);
		logic [DATA_W-1:0] w;
		w               = '0;
		w[BIT_TRIM_HI]  = trim[1];
		w[BIT_TRIM_LO]  = trim[0];
		w[BIT_BROWNOUT] = flag;
		return w;
	endfunction

	// combinational helpers
	logic                    det_on;      // detector enabled by option
	logic                    low_supply;  // supply below the active threshold
	logic                    wr_integ;    // write to integrity register
	logic                    rd_integ;    // read of integrity register
	logic                    pulse_req;   // watchdog or illegal code
	logic                    dip_end;     // supply reset ends this cycle
	logic                    flag_ok;     // dip qualifies for brownout flag
	logic [EV_W-1:0]         ev_set;      // events this cycle
	logic [PULSE_CNT_W-1:0]  pulse_load;  // pulse reset length minus one

	assign pulse_load = PULSE_CNT_W'(PULSE_CYC - 1);

	// next state
	always_comb begin
		next_cur   = cur;
		det_on     = opt_detector_en; // see R13
		wr_integ   = reg_wr && (reg_addr == OFS_INTEGRITY);
		rd_integ   = reg_rd && (reg_addr == OFS_INTEGRITY);
		pulse_req  = wdg_reset_req || illegal_opcode || illegal_prebyte; // see R12
		low_supply = 1'b0;
		dip_end    = 1'b0;
		flag_ok    = 1'b0;
		ev_set     = '0;

		// hysteresis: climb out on the rising threshold, drop in on the falling one
		if (det_on) begin
			if (cur.state == ST_SUPPLY) begin
				low_supply = !above_rise; // see R1
			end else begin
				low_supply = !above_fall; // see R1
			end
		end
		// a disabled detector ignores the comparator entirely
		if (!det_on) begin
			low_supply = 1'b0; // see R14
		end

		// threshold level chosen by option, sent to the analog side
		next_cur.thr_sel = opt_high_threshold; // see R13

		// reset sequencer
		case (cur.state)
			ST_RUN: begin
				if (low_supply) begin
					next_cur.state    = ST_SUPPLY; // see R1
					next_cur.dip_cnt  = '0;
					next_cur.dip_halt = in_halt;
				end else if (pulse_req) begin
					next_cur.state     = ST_PULSE;
					next_cur.pulse_cnt = pulse_load;
				end
			end
			ST_SUPPLY: begin
				// count the dip, saturating
				if (cur.dip_cnt != {DIP_CNT_W{1'b1}}) begin
					next_cur.dip_cnt = cur.dip_cnt + 1'b1;
				end
				if (!low_supply) begin
					next_cur.state = ST_RUN;
					dip_end        = 1'b1;
				end
			end
			ST_PULSE: begin
				// supply failure overrides a running pulse reset
				if (low_supply) begin
					next_cur.state    = ST_SUPPLY; // see R1
					next_cur.dip_cnt  = '0;
					next_cur.dip_halt = in_halt;
				end else if (cur.pulse_cnt == '0) begin
					next_cur.state = ST_RUN;
				end else begin
					next_cur.pulse_cnt = cur.pulse_cnt - 1'b1;
				end
			end
			default: begin
				next_cur.state = ST_RUN;
			end
		endcase

		// decide whether the ending dip may record the brownout flag
		if (clk_src_external) begin
			flag_ok = !cur.dip_halt && ext_clk_fast; // see R8
		end else begin
			flag_ok = (32'(cur.dip_cnt) + 32'd1) >= FILTER_CYC; // see R7
		end

		// chip reset level and pin drive
		next_cur.chip_rst = (next_cur.state != ST_RUN) || !pin_high;
		next_cur.pin_oe_n = (next_cur.state != ST_SUPPLY); // see R2

		// trim bits reset with the chip, written by software afterwards
		if (cur.chip_rst) begin
			next_cur.trim_lo = RST_TRIM_LO; // see R11
		end else if (wr_integ) begin
			// reserved bits are not stored, the flag is not writable
			next_cur.trim_lo = {reg_wdata[BIT_TRIM_HI], reg_wdata[BIT_TRIM_LO]}; // see R9 see R15 see R10
		end

		// brownout flag: read clears, a new qualifying dip sets and wins;
		// watchdog, pin and illegal code resets leave it alone
		if (rd_integ) begin
			next_cur.brownout = 1'b0; // see R4 see R15
		end
		if (dip_end && flag_ok) begin
			next_cur.brownout = 1'b1; // see R4 see R5 see R6
		end

		// watchdog flag: set by watchdog reset, cleared by a supply reset
		if (wdg_flag_clr) begin
			next_cur.wdg_flag = 1'b0;
		end
		if (wdg_reset_req) begin
			next_cur.wdg_flag = 1'b1;
		end
		if (next_cur.state == ST_SUPPLY) begin
			next_cur.wdg_flag = 1'b0; // see R3
		end

		// events for the interrupt status
		ev_set[EV_LVD]     = (cur.state != ST_SUPPLY) && (next_cur.state == ST_SUPPLY);
		ev_set[EV_WDG]     = wdg_reset_req;
		ev_set[EV_ILLEGAL] = illegal_opcode || illegal_prebyte;

		// clear register first so that a same-cycle event wins
		if (reg_wr && (reg_addr == OFS_IRQ_CLEAR)) begin
			next_cur.ev_stat = cur.ev_stat & ~reg_wdata[EV_W-1:0];
		end
		next_cur.ev_stat = next_cur.ev_stat | ev_set;

		// enable register
		if (reg_wr && (reg_addr == OFS_IRQ_ENABLE)) begin
			next_cur.ev_en = reg_wdata[EV_W-1:0];
		end

		// interrupt level from next status and enables, registered together with them
		next_cur.irq = |(next_cur.ev_stat & next_cur.ev_en);

		// read data stands only in the cycle after the read strobe
		next_cur.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_INTEGRITY: begin
					next_cur.rdata = integrity_word(cur.trim_lo, cur.brownout);
				end
				OFS_IRQ_STATUS: begin
					next_cur.rdata = {{(DATA_W-EV_W){1'b0}}, cur.ev_stat};
				end
				OFS_IRQ_ENABLE: begin
					next_cur.rdata = {{(DATA_W-EV_W){1'b0}}, cur.ev_en};
				end
				default: begin
					next_cur.rdata = '0; // clear register and unmapped read zero
				end
			endcase
		end
	end

	// register the state; rstn is power-on only, chip resets act above
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cur           <= '0;
			cur.state     <= ST_RUN;
			cur.brownout  <= RST_BROWNOUT;
			cur.trim_lo   <= RST_TRIM_LO;
			cur.ev_en     <= RST_IRQ_EN;
			cur.chip_rst  <= 1'b1;
			cur.pin_oe_n  <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from the state register, except reset_pin_out which is tied low
	assign reg_rdata           = cur.rdata;
	assign reset_pin_out       = 1'b0;
	assign reset_pin_oe_n      = cur.pin_oe_n;
	assign chip_reset          = cur.chip_rst;
	assign threshold_high_sel  = cur.thr_sel;
	assign watchdog_reset_flag = cur.wdg_flag;
	assign rc_trim_low         = cur.trim_lo;
	assign irq                 = cur.irq;
endmodule

// *** testbench/sirf_pin_peer.sv ***
// Purpose: other devices on the shared open reset line
// Assumes: line has a pull-up
// Notes: any party may pull the line low
`timescale 1ns/1ps
module sirf_pin_peer (
	input  wire logic drv_val,
	input  wire logic drv_oe_n,
	input  wire logic ext_rst,
	output logic      pin
);
	// wired-and of the block's drive and a peer's reset, pull-up otherwise
	assign pin = ((!drv_oe_n && !drv_val) || ext_rst) ? 1'b0 : 1'b1;
endmodule

// *** testbench/sirf_props.sv ***
// Purpose: port level checks for the supply integrity block
// Assumes: sees only the ports of sirf_top
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ps
module sirf_props
	import sirf_pkg::*;
#(
	parameter int unsigned PULSE_CYC = 4
) (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       opt_detector_en,
	input wire logic       wdg_reset_req,
	input wire logic       illegal_opcode,
	input wire logic       illegal_prebyte,
	input wire logic       reset_pin_out,
	input wire logic       reset_pin_oe_n,
	input wire logic       chip_reset,
	input wire logic       watchdog_reset_flag,
	input wire logic [1:0] rc_trim_low
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// read strobe aimed at the integrity byte
	sequence s_rd_int;
		reg_rd && reg_addr == OFS_INTEGRITY;
	endsequence
	// illegal opcode or prebyte seen while running
	sequence s_bad_code;
		(illegal_opcode || illegal_prebyte) && !chip_reset;
	endsequence
	AST_PIN_DRIVE: assert property (!reset_pin_oe_n |-> chip_reset && !reset_pin_out)
		else $error("reset pin driven outside reset");
	AST_DET_OFF: assert property ($fell(reset_pin_oe_n) |-> $past(opt_detector_en))
		else $error("supply reset with detector off");
	AST_RD_RSVD: assert property (s_rd_int |=> (reg_rdata & 8'h9b) == 8'h00)
		else $error("reserved bits read nonzero");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	AST_TRIM_WR: assert property (reg_wr && reg_addr == OFS_INTEGRITY && !chip_reset
		|=> chip_reset || rc_trim_low == $past(reg_wdata[6:5]))
		else $error("trim write lost");
	AST_TRIM_CLR: assert property (chip_reset |=> rc_trim_low == 2'h0)
		else $error("trim kept through chip reset");
	AST_WDG_CLR: assert property (!reset_pin_oe_n |-> !watchdog_reset_flag)
		else $error("watchdog flag kept in supply reset");
	AST_WDG_SET: assert property (wdg_reset_req && reset_pin_oe_n
		|=> watchdog_reset_flag || !reset_pin_oe_n)
		else $error("watchdog flag not set");
	AST_PULSE: assert property (s_bad_code |=> chip_reset[*4])
		else $error("illegal code reset too short");
	AST_FLAG_RD: assert property (s_rd_int ##1 (reg_rd && reg_addr == OFS_INTEGRITY
		&& reg_rdata[2] && !chip_reset) |=> !reg_rdata[2])
		else $error("brownout flag not cleared by read");
endmodule
bind sirf_top sirf_props #(.PULSE_CYC(PULSE_CYC)) props_u (.ref_clk, .rstn, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .opt_detector_en, .wdg_reset_req, .illegal_opcode, .illegal_prebyte,
	.reset_pin_out, .reset_pin_oe_n, .chip_reset, .watchdog_reset_flag, .rc_trim_low);

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for sirf_top
// Assumes: short filter and pulse counts
// Notes: plain register cases run from a table
`timescale 1ns/1ps
module testbench;
	import sirf_pkg::*;
	logic       ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic       opt_detector_en = 1'b1, opt_high_threshold = 1'b0, ext_rst = 1'b0;
	logic       cmp_above_rising = 1'b1, cmp_above_falling = 1'b1, clk_src_external = 1'b0;
	logic       ext_clk_fast = 1'b0, in_halt = 1'b0, wdg_reset_req = 1'b0, wdg_flag_clr = 1'b0;
	logic       illegal_opcode = 1'b0, illegal_prebyte = 1'b0, reset_pin_in, reset_pin_out;
	logic       reset_pin_oe_n, chip_reset, threshold_high_sel, watchdog_reset_flag, irq;
	logic [1:0] rc_trim_low;
	int         n_errors = 0, checks_done = 0;
	// write flag, address, data, expected read
	logic [7:0] rows [12][4] = '{'{1, 8'h3d, 8'h07, 0}, '{0, 8'h3b, 0, 0}, '{1, 8'h3b, 8'h07, 0},
		'{0, 8'h3b, 0, 0}, '{1, 8'h3a, 8'h60, 0}, '{0, 8'h3a, 0, 8'h60}, '{1, 8'h3a, 8'h20, 0},
		'{0, 8'h3a, 0, 8'h20}, '{1, 8'h3c, 8'h07, 0}, '{0, 8'h3c, 0, 8'h07}, '{0, 8'h3d, 0, 0},
		'{0, 8'h55, 0, 0}};
	always #12.5 ref_clk = ~ref_clk;
	sirf_top #(.FILTER_CYC(8), .PULSE_CYC(4)) dut_u (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .opt_detector_en, .opt_high_threshold, .cmp_above_rising, .cmp_above_falling,
		.clk_src_external, .ext_clk_fast, .in_halt, .wdg_reset_req, .wdg_flag_clr, .illegal_opcode,
		.illegal_prebyte, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n, .chip_reset,
		.threshold_high_sel, .watchdog_reset_flag, .rc_trim_low, .irq);
	sirf_pin_peer peer_u (.drv_val(reset_pin_out), .drv_oe_n(reset_pin_oe_n), .ext_rst, .pin(reset_pin_in));
	// compare and count
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// one-cycle read, data checked in the following cycle
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk("reg_rdata", reg_rdata, e);
	endtask
	// supply dip: both comparators low, falling side recovers g cycles before rising
	task automatic dip(input int n, input int g);
		@(posedge ref_clk);
		cmp_above_falling <= 1'b0;
		cmp_above_rising  <= 1'b0;
		repeat (n) @(posedge ref_clk);
		cmp_above_falling <= 1'b1;
		repeat (g) @(posedge ref_clk);
		if (g > 0) chk("chip_reset", chip_reset, 8'h01);
		if (g > 0) chk("reset_pin", reset_pin_in, 8'h00);
		cmp_above_rising <= 1'b1;
		// a short dip must still reach the static reset before it clears
		if (g == 0) begin
			repeat (3) @(posedge ref_clk);
			chk("chip_reset", chip_reset, 8'h01);
		end
		repeat (16) @(posedge ref_clk);
		chk("chip_reset", chip_reset, 8'h00);
	endtask
	// watchdog reset request pulse
	task automatic wdg_pulse;
		@(posedge ref_clk);
		wdg_reset_req <= 1'b1;
		@(posedge ref_clk);
		wdg_reset_req <= 1'b0;
		repeat (12) @(posedge ref_clk);
	endtask
	// verdict
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rdc(OFS_INTEGRITY, 8'h00);
		for (int i = 0; i < 12; i++) begin
			if (rows[i][0][0]) wr(rows[i][1], rows[i][2]);
			else rdc(rows[i][1], rows[i][3]);
		end
		wdg_pulse();
		chk("wdg_flag", watchdog_reset_flag, 8'h01);
		chk("irq", irq, 8'h01);
		dip(20, 6);
		chk("wdg_flag", watchdog_reset_flag, 8'h00);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= OFS_INTEGRITY;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk("reg_rdata", reg_rdata, 8'h04);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk("reg_rdata", reg_rdata, 8'h00);
		dip(20, 6);
		wr(OFS_INTEGRITY, 8'h60);
		wdg_pulse();
		ext_rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		ext_rst <= 1'b0;
		repeat (12) @(posedge ref_clk);
		rdc(OFS_INTEGRITY, 8'h04);
		dip(4, 0);
		rdc(OFS_INTEGRITY, 8'h00);
		clk_src_external <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			in_halt      <= (i == 0);
			ext_clk_fast <= (i == 2);
			dip(20, 6);
			in_halt <= 1'b0;
			rdc(OFS_INTEGRITY, (i == 2) ? 8'h04 : 8'h00);
		end
		clk_src_external <= 1'b0;
		opt_detector_en  <= 1'b0;
		cmp_above_falling <= 1'b0;
		cmp_above_rising  <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk("chip_reset", chip_reset, 8'h00);
		cmp_above_falling <= 1'b1;
		cmp_above_rising  <= 1'b1;
		opt_high_threshold <= 1'b1;
		repeat (6) @(posedge ref_clk);
		opt_detector_en <= 1'b1;
		chk("threshold_sel", threshold_high_sel, 8'h01);
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			illegal_opcode  <= (i == 0);
			illegal_prebyte <= (i == 1);
			@(posedge ref_clk);
			illegal_opcode  <= 1'b0;
			illegal_prebyte <= 1'b0;
			@(negedge ref_clk);
			chk("chip_reset", chip_reset, 8'h01);
			repeat (10) @(posedge ref_clk);
			chk("chip_reset", chip_reset, 8'h00);
		end
		wr(OFS_IRQ_ENABLE, 8'h00);
		wr(OFS_IRQ_CLEAR, 8'h07);
		wdg_pulse();
		chk("irq", irq, 8'h00);
		rdc(OFS_IRQ_STATUS, 8'h02);
		wr(OFS_IRQ_ENABLE, 8'h02);
		repeat (2) @(posedge ref_clk);
		chk("irq", irq, 8'h01);
		wr(OFS_IRQ_CLEAR, 8'h02);
		repeat (2) @(posedge ref_clk);
		chk("irq", irq, 8'h00);
		// watchdog block clears its flag on its own strobe
		chk("wdg_flag", watchdog_reset_flag, 8'h01);
		wdg_flag_clr <= 1'b1;
		@(posedge ref_clk);
		wdg_flag_clr <= 1'b0;
		@(negedge ref_clk);
		chk("wdg_flag", watchdog_reset_flag, 8'h00);
		close_out();
	end
endmodule
